/* File: hdl/input_conditioner.sv */
// Purpose: synchronise the isolated inputs and apply the per-input low-pass hold
// Assumes: raw inputs are 1 while energized; switch bits are 1 when the filter is on
// Notes: a filtered input rises at once and falls only after a full hold time low
`timescale 1ns/1ns
`default_nettype none
module input_conditioner #(
  parameter logic [19:0] HOLD_CYCLES = 20'd500000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] raw_in,
  input wire logic [7:0] filter_on,
  output logic [7:0] clean_out
);
  import relay_io_pkg::*;

  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] fon_meta_q;
  logic [7:0] fon_q;
  logic [7:0] out_q, out_d;
  logic [FILTER_CNT_W-1:0] cnt_q [CHAN_N];
  logic [FILTER_CNT_W-1:0] cnt_d [CHAN_N];

  // per-input hold counter: reload while high, count down while low
  always_comb begin
    for (int i = 0; i < CHAN_N; i++) begin
      cnt_d[i] = cnt_q[i];
      out_d[i] = out_q[i];
      if (!fon_q[i]) begin
        cnt_d[i] = '0;
        out_d[i] = sync_q[i];
      end else if (sync_q[i]) begin
        cnt_d[i] = HOLD_CYCLES;
        out_d[i] = 1'b1;
      end else if (cnt_q[i] != '0) begin
        cnt_d[i] = cnt_q[i] - 20'd1;
      end else begin
        out_d[i] = 1'b0;
      end
    end
  end

  // two-flop synchronisers and filter state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      fon_meta_q <= 8'h00;
      fon_q <= 8'h00;
      out_q <= 8'h00;
      for (int i = 0; i < CHAN_N; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      fon_meta_q <= filter_on;
      fon_q <= fon_meta_q;
      out_q <= out_d; // [R13]
      for (int i = 0; i < CHAN_N; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  assign clean_out = out_q;
endmodule // input_conditioner
`default_nettype wire

/* File: hdl/relay_input_io_port_decode.sv */
// Purpose: host I/O decode and register bank of an eight-relay, eight-input module
// Assumes: host strobes and address arrive asynchronously and are sampled at 20 MHz
// Notes: writes take effect at the trailing edge of the write strobe
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (R1) Claims four consecutive I/O bytes at any four-byte aligned base.
// (R2) Base is the sum of installed jumper weights, 0x200 down to 0x004.
// (R3) Shipped jumper pattern gives base 0x300.
// (R4) Host should pick a base above 0x0ff clear of other hardware.
// (R5) Reads of write-only locations may return anything.
// (R6) Writes to read-only locations are harmless and have no effect.
// (R7) Offset 0 is the read/write relay control byte, bit n drives relay n.
// (R8) Offset 1 reads the present state of the eight inputs.
// (R9) Input 0 is the interrupt source; offset 2 reads its flag in bit 0.
// (R10) All relays are released while reset is asserted.
// (R11) Host data path is eight bits wide.
// (R12) Interrupt jumpers enable and pick the line; upper lines need the extension.
// (R13) Each filter switch enables a low-pass filter on its own input.
// (R14) A one energizes the relay, a zero releases it; reads return stored bits.
// (R15) Relay control clears to zero on reset.
// (R16) Input status bit is one while its input is energized.
// (R17) Selected only when address bits 9..2 match jumpers; bits 1..0 pick offset.
// (R18) Data bus driven only during a selected read.
module relay_input_io_port_decode #(
  parameter logic [19:0] FILTER_HOLD = 20'(relay_io_pkg::FILTER_HOLD_CYC)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [relay_io_pkg::ADDR_W-1:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [relay_io_pkg::DATA_W-1:0] sd_in,
  output logic [relay_io_pkg::DATA_W-1:0] sd_out,
  output logic sd_oe,
  input wire logic [7:0] base_address_jumpers,
  input wire logic [relay_io_pkg::IRQ_LINES-1:0] interrupt_select_jumpers,
  input wire logic extension_fitted,
  input wire logic [7:0] field_inputs,
  input wire logic [7:0] filter_switches,
  output logic [7:0] relay_drive,
  output logic [relay_io_pkg::IRQ_LINES-1:0] irq_out,
  output logic [relay_io_pkg::IRQ_LINES-1:0] irq_oe
);
  import relay_io_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } cycle_e;

  // first and second stage of the host pin synchronisers
  logic [ADDR_W-1:0] sa_meta_q, sa_q;
  logic [DATA_W-1:0] sd_meta_q, sd_q;
  logic [3:0] ctl_meta_q, ctl_q; // aen, ior_n, iow_n, extension
  logic [7:0] jmp_meta_q, jmp_q;
  logic [IRQ_LINES-1:0] isel_meta_q, isel_q;

  // cycle tracking
  cycle_e state_q, state_d;
  logic [OFFS_W-1:0] offs_q, offs_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;

  // register bank
  logic [7:0] relay_ctrl_q, relay_ctrl_d;
  logic event_flag_q, event_flag_d;
  logic in0_prev_q;
  logic [DATA_W-1:0] sd_out_q, sd_out_d;
  logic sd_oe_q, sd_oe_d;

  logic [7:0] input_state;
  logic aen_s, ior_s_n, iow_s_n, ext_s;
  logic hit;
  logic rd_done, wr_done;
  logic in0_rise;

  // address match against jumper pattern; position one carries the top weight
  function automatic logic addr_match(input logic [ADDR_W-1:0] a, input logic [7:0] j, input logic en_n);
    addr_match = !en_n && (a[ADDR_W-1:BASE_LSB] == j); // [R1] [R2] [R17]
  endfunction

  // read mux for the implemented offsets
  function automatic logic [DATA_W-1:0] read_value(input logic [OFFS_W-1:0] o, input logic [7:0] ctrl,
                                                  input logic [7:0] ins, input logic flag);
    read_value = 8'h00;
    unique case (o)
      OFFS_RELAY_CTRL: read_value = ctrl; // [R7] [R14]
      OFFS_INPUT_STATUS: read_value = ins; // [R8] [R16]
      OFFS_IRQ_STATUS: read_value = IRQ_STATUS_PAD | (8'(flag) << EVENT_FLAG_POS); // [R9]
      OFFS_RESERVED: read_value = 8'h00;
    endcase
  endfunction

  // input synchronising and low-pass filtering
  input_conditioner #(
    .HOLD_CYCLES(FILTER_HOLD)
  ) u_cond (
    .clk(clk),
    .arst_n(arst_n),
    .raw_in(field_inputs),
    .filter_on(filter_switches),
    .clean_out(input_state)
  );

  // two-flop synchronisers for every host-side pin and jumper
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sa_meta_q <= '0;
      sa_q <= '0;
      sd_meta_q <= 8'h00;
      sd_q <= 8'h00;
      ctl_meta_q <= 4'h7;
      ctl_q <= 4'h7;
      jmp_meta_q <= FACTORY_JUMPERS; // [R3]
      jmp_q <= FACTORY_JUMPERS;
      isel_meta_q <= '0;
      isel_q <= '0;
    end else begin
      sa_meta_q <= sa;
      sa_q <= sa_meta_q;
      sd_meta_q <= sd_in;
      sd_q <= sd_meta_q;
      ctl_meta_q <= {extension_fitted, iow_n, ior_n, aen};
      ctl_q <= ctl_meta_q;
      jmp_meta_q <= base_address_jumpers;
      jmp_q <= jmp_meta_q;
      isel_meta_q <= interrupt_select_jumpers;
      isel_q <= isel_meta_q;
    end
  end

  assign aen_s = ctl_q[0];
  assign ior_s_n = ctl_q[1];
  assign iow_s_n = ctl_q[2];
  assign ext_s = ctl_q[3];
  assign hit = addr_match(sa_q, jmp_q, aen_s);

  // bus cycle tracker: latch offset and data while a selected strobe is low
  always_comb begin
    state_d = state_q;
    offs_d = offs_q;
    wdata_d = wdata_q;
    rd_done = 1'b0;
    wr_done = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (hit && !ior_s_n) begin
          state_d = ST_READ;
          offs_d = sa_q[OFFS_W-1:0]; // [R17]
        end else if (hit && !iow_s_n) begin
          state_d = ST_WRITE;
          offs_d = sa_q[OFFS_W-1:0];
          wdata_d = sd_q;
        end
      end
      ST_READ: begin
        if (ior_s_n) begin
          state_d = ST_IDLE;
          rd_done = 1'b1;
        end
      end
      ST_WRITE: begin
        if (iow_s_n) begin
          state_d = ST_IDLE;
          wr_done = 1'b1;
        end else begin
          wdata_d = sd_q; // follow data until the trailing edge
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      offs_q <= 2'h0;
      wdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      offs_q <= offs_d;
      wdata_q <= wdata_d;
    end
  end

  assign in0_rise = input_state[INPUT_IRQ_SRC] && !in0_prev_q;

  // register bank next state
  always_comb begin
    relay_ctrl_d = relay_ctrl_q;
    event_flag_d = event_flag_q;
    // only offset 0 stores; writes elsewhere are dropped
    if (wr_done && offs_q == OFFS_RELAY_CTRL) begin
      relay_ctrl_d = wdata_q; // [R7] [R14] [R6] [R11]
    end
    // reading the status clears the flag; a new event in the same cycle wins
    if (rd_done && offs_q == OFFS_IRQ_STATUS) begin
      event_flag_d = 1'b0;
    end
    if (in0_rise) begin
      event_flag_d = 1'b1; // [R9]
    end
    // drive data only while a selected read of an implemented offset is in progress
    sd_oe_d = (state_d == ST_READ) && (offs_d != OFFS_RESERVED); // [R18] [R5]
    sd_out_d = read_value(offs_d, relay_ctrl_q, input_state, event_flag_q);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relay_ctrl_q <= RELAY_CTRL_RST; // [R15] [R10]
      event_flag_q <= 1'b0;
      in0_prev_q <= 1'b0;
      sd_out_q <= 8'h00;
      sd_oe_q <= 1'b0;
    end else begin
      relay_ctrl_q <= relay_ctrl_d;
      event_flag_q <= event_flag_d;
      in0_prev_q <= input_state[INPUT_IRQ_SRC];
      sd_out_q <= sd_out_d;
      sd_oe_q <= sd_oe_d;
    end
  end

  // outputs
  assign relay_drive = relay_ctrl_q; // [R14] [R10]
  assign sd_out = sd_out_q;
  assign sd_oe = sd_oe_q; // [R18]
  // selected line carries the flag; upper lines only with the extension fitted
  assign irq_oe = isel_q & (ext_s ? {IRQ_LINES{1'b1}} : ~IRQ_UPPER_MASK); // [R12]
  assign irq_out = irq_oe & {IRQ_LINES{event_flag_q}}; // [R9] [R12]
endmodule // relay_input_io_port_decode
`default_nettype wire

/* File: hdl/relay_io_pkg.sv */
// Purpose: shared constants for the relay output / isolated input port decode
// Assumes: 8-bit host data, 10-bit I/O address, 20 MHz core clock
// Notes: offsets are byte offsets from the jumper-selected base
package relay_io_pkg;
  // host bus shape
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned OFFS_W = 2;
  localparam int unsigned PORT_SPAN = 4; // bytes claimed by the block
  // register offsets
  localparam logic [1:0] OFFS_RELAY_CTRL = 2'h0;
  localparam logic [1:0] OFFS_INPUT_STATUS = 2'h1;
  localparam logic [1:0] OFFS_IRQ_STATUS = 2'h2;
  localparam logic [1:0] OFFS_RESERVED = 2'h3;
  // field positions
  localparam int unsigned EVENT_FLAG_POS = 0; // event flag bit in interrupt_status
  localparam int unsigned INPUT_IRQ_SRC = 0; // input that feeds the interrupt
  localparam int unsigned BASE_LSB = 2; // lowest address bit set by the jumpers
  // reset values
  localparam logic [7:0] RELAY_CTRL_RST = 8'h00;
  localparam logic [7:0] FACTORY_JUMPERS = 8'hC0; // positions one and two installed: base 0x300
  localparam logic [7:0] IRQ_STATUS_PAD = 8'h00;
  // interrupt request lines: 3,4,5,6,7,9 on the primary connector, 10,11,12,14,15 on the extension
  localparam int unsigned IRQ_LINES = 11;
  localparam logic [10:0] IRQ_UPPER_MASK = 11'h7C0;
  // input low-pass hold time
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FILTER_HOLD_US = 25000;
  localparam int unsigned FILTER_HOLD_CYC = (CLK_HZ / 1000000) * FILTER_HOLD_US;
  localparam int unsigned FILTER_CNT_W = 20;
endpackage

/* File: verif/isa_host.sv */
// Purpose: host processor model on the 8-bit I/O bus
// Assumes: tasks are entered 1 ns after a rising clock edge
// Notes: strobes held 4+ clocks, 6-clock gap; released data shows the inverse
`timescale 1ns/1ns
`default_nettype none
module isa_host (
  input wire logic clk,
  output logic [9:0] sa,
  output logic aen,
  output logic ior_n,
  output logic iow_n,
  output logic [7:0] sd_in,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe
);
  // idle bus at time zero
  initial begin
    sa = 10'h000;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    sd_in = 8'hFF;
  end
  // one write cycle; dma high marks a cycle the device must ignore
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic dma);
    sa = a;
    aen = dma;
    sd_in = d;
    iow_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 iow_n = 1'b1;
    // keep data and qualifier until the trailing edge has been seen, then release
    repeat (3) @(posedge clk);
    #1 sd_in = ~d;
    aen = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // one read cycle, strobe held until the device drives or 8 clocks pass
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
    sa = a;
    ior_n = 1'b0;
    oe = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 8 && !oe; n++) begin
      @(posedge clk);
      #1 oe = sd_oe;
      d = sd_oe ? sd_out : ~sd_out; // released bus shows the inverse
    end
    // strobe stands through the edge at which the drive is seen high
    @(posedge clk);
    #1 ior_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
endmodule // isa_host
`default_nettype wire

/* File: verif/relay_io_checker_assertions.sv */
// Purpose: port checker for the relay and input decode block
// Assumes: address held from strobe fall until six clocks after it rises
// Notes: read answer lags the strobe fall by three edges, write lags the strobe rise by three
`timescale 1ns/1ns
`default_nettype none
module relay_io_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [9:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe,
  input wire logic [7:0] base_address_jumpers,
  input wire logic extension_fitted,
  input wire logic [10:0] interrupt_select_jumpers,
  input wire logic [7:0] relay_drive,
  input wire logic [10:0] irq_out,
  input wire logic [10:0] irq_oe
);
  import relay_io_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // relays released out of reset
  relays_reset_a: assert property ($rose(arst_n) |-> relay_drive == 8'h00)
    else $error("relays not released after reset");
  // bus driven only inside a selected read of a real register
  drive_on_read_a: assert property (sd_oe |-> !$past(ior_n, 2) || !$past(ior_n, 3) || !$past(ior_n, 4))
    else $error("data bus driven outside a read");
  select_match_a: assert property (sd_oe |-> $past(sa[9:2], 3) == $past(base_address_jumpers, 3)
    && !$past(aen, 3) && $past(sa[1:0], 3) != 2'h3) else $error("read answered without a match");
  // read data per offset
  relay_readback_a: assert property (sd_oe && $past(sa[1:0], 3) == 2'h0 |-> sd_out == relay_drive)
    else $error("relay byte read back wrong");
  flag_pad_a: assert property (sd_oe && $past(sa[1:0], 3) == 2'h2 |-> sd_out[7:1] == 7'h00)
    else $error("flag byte upper bits set");
  // relays move only after a write strobe to offset 0
  write_only_a: assert property (!$stable(relay_drive) |-> $past(sa[1:0], 4) == 2'h0 && !$past(aen, 4)
    && (!$past(iow_n, 5) || !$past(iow_n, 6))) else $error("relays changed without a write");
  // interrupt line selection
  // a raised line drops only when its enable moves or the flag byte was just read
  irq_clear_a: assert property ($fell(|irq_out) |-> (irq_oe != $past(irq_oe))
    || ($past(sd_oe) && $past(sa[1:0]) == 2'h2)) else $error("interrupt dropped without a flag read");
  // enabled lines follow the select jumpers two edges later, upper ones only with the extension
  irq_select_a: assert property ($past(arst_n, 2) |-> irq_oe == ($past(interrupt_select_jumpers, 2)
    & ($past(extension_fitted, 2) ? 11'h7FF : ~IRQ_UPPER_MASK))) else $error("interrupt enable not as selected");
  onehot_line_a: assert property ($onehot0(irq_oe))
    else $error("more than one interrupt line driven");
  upper_needs_ext_a: assert property (|(irq_oe & IRQ_UPPER_MASK) |-> $past(extension_fitted, 2))
    else $error("upper line driven without extension");
  // main scenarios reached
  cover property (sd_oe && $past(sa[1:0], 3) == 2'h2);
  cover property (!$stable(relay_drive));
  cover property (|irq_out);
endmodule // relay_io_checker
bind relay_input_io_port_decode relay_io_checker relay_io_checker_i (.clk, .arst_n, .sa, .aen, .ior_n, .iow_n,
  .sd_out, .sd_oe, .base_address_jumpers, .extension_fitted, .interrupt_select_jumpers, .relay_drive, .irq_out,
  .irq_oe);
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: self-checking bench for the relay and input decode block
// Assumes: inputs change 1 ns after a rising edge
// Notes: filter hold shortened to 20 clocks
`timescale 1ns/1ns
`default_nettype none
module tb;
  import relay_io_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ext = 1'b0;
  logic aen, ior_n, iow_n, sd_oe, rd_oe;
  logic [9:0] sa;
  logic [7:0] sd_in, sd_out, rd_d, relays;
  logic [7:0] base_j = FACTORY_JUMPERS;
  logic [7:0] fin = 8'h00;
  logic [7:0] filt = 8'h00;
  logic [10:0] irq_sel = 11'h000;
  logic [10:0] irq_out, irq_oe;
  int n_mismatch = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  relay_input_io_port_decode #(.FILTER_HOLD(20'd20)) relay_input_io_port_decode_i (.clk, .arst_n, .sa, .aen,
    .ior_n, .iow_n, .sd_in, .sd_out, .sd_oe, .base_address_jumpers(base_j), .interrupt_select_jumpers(irq_sel),
    .extension_fitted(ext), .field_inputs(fin), .filter_switches(filt), .relay_drive(relays), .irq_out, .irq_oe);
  isa_host isa_host_i (.clk, .sa, .aen, .ior_n, .iow_n, .sd_in, .sd_out, .sd_oe);
  // compare helpers
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    isa_host_i.rd(a, rd_d, rd_oe);
    chk1("read drive", 1'b1, rd_oe);
    chk8("read data", e, rd_d);
  endtask
  task automatic wt();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #3000000;
    n_mismatch++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    wt();
    chk8("relays", 8'h00, relays);
    rdc(10'h300, 8'h00);
    rdc(10'h302, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      isa_host_i.wr(10'h300, 8'hA5 ^ {8{i[0]}}, 1'b0);
      chk8("relays", 8'hA5 ^ {8{i[0]}}, relays);
      rdc(10'h300, 8'hA5 ^ {8{i[0]}});
    end
    for (int i = 0; i < 6; i++) begin
      isa_host_i.wr(i < 5 ? 10'h301 + 10'(i) : 10'h300, 8'hFF, i == 5);
    end
    chk8("relays", 8'h5A, relays);
    fin = 8'hC3;
    wt();
    rdc(10'h301, 8'hC3);
    isa_host_i.rd(10'h303, rd_d, rd_oe);
    chk1("reserved drive", 1'b0, rd_oe);
    $display("test registers done");
    base_j = 8'h41;
    wt();
    isa_host_i.wr(10'h104, 8'h3C, 1'b0);
    chk8("relays", 8'h3C, relays);
    rdc(10'h104, 8'h3C);
    isa_host_i.rd(10'h300, rd_d, rd_oe);
    chk1("old base drive", 1'b0, rd_oe);
    base_j = FACTORY_JUMPERS;
    irq_sel = 11'h001;
    wt();
    $display("test base done");
    chk1("irq line", 1'b1, irq_out[0]);
    chk1("irq enable", 1'b1, irq_oe[0]);
    rdc(10'h302, 8'h01);
    rdc(10'h302, 8'h00);
    chk1("irq line", 1'b0, irq_out[0]);
    irq_sel = 11'h000;
    wt();
    ext = 1'b1;
    wt();
    irq_sel = 11'h040;
    wt();
    chk1("upper enable", 1'b1, irq_oe[6]);
    irq_sel = 11'h000;
    wt();
    ext = 1'b0;
    wt();
    irq_sel = 11'h040;
    wt();
    chk1("upper enable", 1'b0, irq_oe[6]);
    $display("test interrupt done");
    filt = 8'h02;
    fin = 8'h06;
    wt();
    fin = 8'h00;
    wt();
    rdc(10'h301, 8'h02);
    repeat (30) @(posedge clk);
    #1;
    rdc(10'h301, 8'h00);
    $display("test filter done");
    isa_host_i.wr(10'h300, 8'hFF, 1'b0);
    chk8("relays", 8'hFF, relays);
    arst_n = 1'b0;
    wt();
    chk8("relays", 8'h00, relays);
    arst_n = 1'b1;
    wt();
    rdc(10'h300, 8'h00);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
